/* File: eas_eeprom_seq.sv */
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "eas_defs.svh"
module eas_eeprom_seq
   import eas_pkg::*;
#(
   parameter int          ADDR_W     = 10,
   parameter int unsigned ATOMIC_CYC =
      int'(`EAS_T_ATOMIC_MS * 1000.0 * `EAS_CLK_MHZ),
   parameter int unsigned SPLIT_CYC  =
      int'(`EAS_T_SPLIT_MS * 1000.0 * `EAS_CLK_MHZ)
) (
   input  wire logic              pclk,    // core clock
   input  wire logic              presetn, // system reset, active low
   input  wire logic              por_n,   // power-on reset, active low
   input  wire logic              psel,    // apb select
   input  wire logic              penable, // apb access phase
   input  wire logic              pwrite,  // apb direction
   input  wire logic [ADDR_W-1:0] paddr,   // apb byte address
   input  wire logic [31:0]       pwdata,  // apb write data
   output logic       [31:0]      prdata,  // apb read data
   output logic                   pready,  // apb ready, stretched on stall
   output logic                   pslverr, // unmapped address
   output logic                   irq      // level interrupt
);

   localparam int         CNT_W      = $clog2(ATOMIC_CYC + 1);
   localparam logic [2:0] RD_STALL   = 3'(`EAS_RD_STALL);
   localparam logic [2:0] PROG_STALL = 3'(`EAS_PROG_STALL);
   localparam logic [2:0] ARM_WIN    = 3'(`EAS_ARM_WINDOW);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
      addr_of = ADDR_W'({idx, 2'b00});
   endfunction : addr_of

   // programming time per mode
   function automatic logic [CNT_W-1:0] prog_cycles(input eas_mode_t m);
      prog_cycles = (m == EAS_M_ATOMIC) ? CNT_W'(ATOMIC_CYC)
                                        : CNT_W'(SPLIT_CYC);
   endfunction : prog_cycles

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   eas_mode_t     mode;
   logic          rie;
   logic          arm;
   logic [2:0]    arm_cnt;
   logic [7:0]    data_q;
   logic [7:0]    addr_q;
   logic [1:0]    istat;
   logic [1:0]    imask;
   eas_bus_st_t   bus_st;
   eas_bus_st_t   next_bus_st;
   logic [2:0]    wcnt;
   logic          acc_rd;
   logic          acc_start;
   logic          acc_refuse;
   logic          busy;
   eas_prog_t     prog;
   eas_cell_cmd_t cell_cmd;
   logic [7:0]    mem_rd;
   logic          tmr_done;
   logic          next_pready;
   logic [1:0]    next_istat;

   // ----------------------------------------------------------------
   // address decode and phases
   // ----------------------------------------------------------------
   wire setup     = psel & ~penable;
   wire commit    = psel & penable & pready;
   wire hit_ctrl  = paddr == addr_of(`EAS_IDX_CTRL);
   wire hit_data  = paddr == addr_of(`EAS_IDX_DATA);
   wire hit_addr  = paddr == addr_of(`EAS_IDX_ADDR);
   wire hit_istat = paddr == addr_of(`EAS_IDX_ISTAT);
   wire hit_imask = paddr == addr_of(`EAS_IDX_IMASK);
   wire mapped    = hit_ctrl | hit_data | hit_addr | hit_istat | hit_imask;
   wire wr_commit = commit & pwrite & mapped;
   wire wr_ctrl   = wr_commit & hit_ctrl;
   wire wr_data   = wr_commit & hit_data;
   wire wr_addr   = wr_commit & hit_addr;
   wire wr_istat  = wr_commit & hit_istat;
   wire wr_imask  = wr_commit & hit_imask;

   // ----------------------------------------------------------------
   // request screening, judged in the setup cycle
   // ----------------------------------------------------------------
   wire       ctl_setup = setup & pwrite & hit_ctrl;
   wire       rd_req    = ctl_setup & pwdata[`EAS_CTRL_RD];
   wire       st_req    = ctl_setup & pwdata[`EAS_CTRL_START];
   wire       rd_ok     = rd_req & ~busy;
   wire       st_ok     = st_req & arm & ~busy & (mode != EAS_M_RSVD);
   wire       refuse    = (rd_req & ~rd_ok) | (st_req & ~st_ok);
   wire [2:0] lat       = st_ok ? PROG_STALL : (rd_ok ? RD_STALL : 3'h0);

   // start pulse into the programming engine
   wire start_go = commit & acc_start;

   // ----------------------------------------------------------------
   // read data selection
   // ----------------------------------------------------------------
   wire [7:0]  ctrl_view = {2'b00, mode, rie, arm, busy, 1'b0};
   wire [31:0] rd_mux    = hit_ctrl  ? 32'(ctrl_view) :
                           hit_data  ? 32'(data_q)    :
                           hit_addr  ? 32'(addr_q)    :
                           hit_istat ? 32'(istat)     :
                           hit_imask ? 32'(imask)     : 32'h0000_0000;

   // ----------------------------------------------------------------
   // bus answer sequencer
   // ----------------------------------------------------------------
   // stall is wait states on the access that asked for it
   always_comb begin
      next_bus_st = bus_st;
      unique case (bus_st)
         EAS_B_IDLE: begin
            if (setup) begin
               next_bus_st = (lat == 3'h0) ? EAS_B_RESP : EAS_B_WAIT;
            end
         end
         EAS_B_WAIT: begin
            if (wcnt == 3'h1) begin
               next_bus_st = EAS_B_RESP;
            end
         end
         EAS_B_RESP: begin
            next_bus_st = EAS_B_IDLE;
         end
         default: begin
            next_bus_st = EAS_B_IDLE;
         end
      endcase
   end

   assign next_pready = next_bus_st == EAS_B_RESP;

   // state, wait count and latched screening result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_st     <= EAS_B_IDLE;
         wcnt       <= 3'h0;
         acc_rd     <= 1'b0;
         acc_start  <= 1'b0;
         acc_refuse <= 1'b0;
      end else begin
         bus_st <= next_bus_st;
         if (bus_st == EAS_B_IDLE && setup) begin
            wcnt       <= lat;
            acc_rd     <= rd_ok;
            acc_start  <= st_ok;
            acc_refuse <= refuse;
         end else if (bus_st == EAS_B_WAIT) begin
            wcnt <= wcnt - 3'h1;
         end
      end
   end

   // registered answer signals
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= next_pready;
         pslverr <= next_pready & ~mapped;
         prdata  <= (next_pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // address and data ignore bus writes during programming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q <= `EAS_RST_BYTE;
         addr_q <= `EAS_RST_BYTE;
         rie    <= 1'b0;
         imask  <= `EAS_RST_IST;
      end else begin
         if (commit & acc_rd) begin
            data_q <= mem_rd;
         end else if (wr_data & ~busy) begin
            data_q <= pwdata[7:0];
         end
         if (wr_addr & ~busy) begin
            addr_q <= pwdata[7:0];
         end
         if (wr_ctrl) begin
            rie <= pwdata[`EAS_CTRL_RIE];
         end
         if (wr_imask) begin
            imask <= pwdata[`EAS_IST_W-1:0];
         end
      end
   end

   // arm bit with its self-clearing window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm     <= 1'b0;
         arm_cnt <= 3'h0;
      end else if (start_go) begin
         arm     <= 1'b0;
         arm_cnt <= 3'h0;
      end else if (wr_ctrl & pwdata[`EAS_CTRL_ARM]) begin
         arm     <= 1'b1;
         arm_cnt <= ARM_WIN;
      end else if (arm) begin
         arm     <= arm_cnt != 3'h1;
         arm_cnt <= arm_cnt - 3'h1;
      end
   end

   // mode lives in the power-on domain so a busy reset keeps it
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         mode <= eas_mode_t'(`EAS_RST_MODE);
      end else if (!presetn) begin
         if (!busy) begin
            mode <= eas_mode_t'(`EAS_RST_MODE);
         end
      end else if (wr_ctrl & ~busy & ~acc_start) begin
         mode <= eas_mode_t'(pwdata[`EAS_CTRL_MODE_HI:`EAS_CTRL_MODE_LO]);
      end
   end

   // ----------------------------------------------------------------
   // programming engine, immune to the system reset
   // ----------------------------------------------------------------
   // operands latched at start so later bus writes cannot disturb it
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         busy <= 1'b0;
         prog <= '0;
      end else if (start_go) begin
         busy <= 1'b1;
         prog <= '{mode: mode, addr: addr_q, data: data_q};
      end else if (tmr_done) begin
         busy <= 1'b0;
      end
   end

   eas_prog_timer #(
      .CNT_W   (CNT_W)
   ) u_timer (
      .clk     (pclk),
      .rst_n   (por_n),
      .load    (start_go),
      .value   (prog_cycles(mode)),
      .running (),
      .done    (tmr_done)
   );

   // cell action chosen by the latched mode
   assign cell_cmd.erase = tmr_done & (prog.mode == EAS_M_ATOMIC ||
                                       prog.mode == EAS_M_ERASE);
   assign cell_cmd.write = tmr_done & (prog.mode == EAS_M_ATOMIC ||
                                       prog.mode == EAS_M_WRITE);
   assign cell_cmd.addr  = prog.addr;
   assign cell_cmd.data  = prog.data;

   eas_nvm_array #(
      .DEPTH   (256)
   ) u_array (
      .clk     (pclk),
      .cmd     (cell_cmd),
      .rd_addr (addr_q),
      .rd_data (mem_rd)
   );

   // ----------------------------------------------------------------
   // interrupt status and output
   // ----------------------------------------------------------------
   // set beats a simultaneous write-one-to-clear
   wire [1:0] ist_set = {commit & acc_refuse, tmr_done};
   wire [1:0] ist_clr = wr_istat ? pwdata[`EAS_IST_W-1:0] : 2'b00;

   assign next_istat = (istat & ~ist_clr) | ist_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat <= `EAS_RST_IST;
         irq   <= 1'b0;
      end else begin
         istat <= next_istat;
         irq   <= (|(istat & imask)) | (rie & ~busy);
      end
   end

endmodule : eas_eeprom_seq

/* File: eas_defs.svh */
`ifndef EAS_DEFS_SVH
`define EAS_DEFS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define EAS_IDX_CTRL     8'h1C
`define EAS_IDX_DATA     8'h1D
`define EAS_IDX_ADDR     8'h1E
`define EAS_IDX_ISTAT    8'h20
`define EAS_IDX_IMASK    8'h21

// ----------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------
`define EAS_CTRL_RD      0
`define EAS_CTRL_START   1
`define EAS_CTRL_ARM     2
`define EAS_CTRL_RIE     3
`define EAS_CTRL_MODE_LO 4
`define EAS_CTRL_MODE_HI 5

// ----------------------------------------------------------------
// interrupt status and mask bit positions
// ----------------------------------------------------------------
`define EAS_IST_DONE     0
`define EAS_IST_REFUSED  1
`define EAS_IST_W        2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EAS_RST_MODE     2'b00
`define EAS_RST_BYTE     8'h00
`define EAS_RST_IST      2'b00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EAS_CLK_MHZ      200
`define EAS_T_ATOMIC_MS  3.4
`define EAS_T_SPLIT_MS   1.8
`define EAS_RD_STALL     4
`define EAS_PROG_STALL   2
`define EAS_ARM_WINDOW   4

`endif

/* File: eas_pkg.sv */
package eas_pkg;

   // programming mode field of the control register
   typedef enum logic [1:0] {
      EAS_M_ATOMIC = 2'b00,
      EAS_M_ERASE  = 2'b01,
      EAS_M_WRITE  = 2'b10,
      EAS_M_RSVD   = 2'b11
   } eas_mode_t;

   // bus answer sequencer, gray along idle-wait-resp
   typedef enum logic [1:0] {
      EAS_B_IDLE = 2'b00,
      EAS_B_WAIT = 2'b01,
      EAS_B_RESP = 2'b11
   } eas_bus_st_t;

   // operation latched at start
   typedef struct packed {
      eas_mode_t  mode;
      logic [7:0] addr;
      logic [7:0] data;
   } eas_prog_t;

   // one cell update command
   typedef struct packed {
      logic       erase;
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } eas_cell_cmd_t;

endpackage : eas_pkg

/* File: eas_nvm_array.sv */
`timescale 1ns/1ps
module eas_nvm_array
   import eas_pkg::*;
#(
   parameter int DEPTH = 256
) (
   input  wire logic          clk,     // core clock
   input  eas_cell_cmd_t      cmd,     // update at end of programming
   input  wire logic [7:0]    rd_addr, // read address
   output logic       [7:0]   rd_data  // read byte, combinational
);

   logic [7:0] mem [DEPTH];
   logic [7:0] base;

   // erase sets all ones; write can only clear bits
   assign base    = cmd.erase ? 8'hFF : mem[cmd.addr];
   assign rd_data = mem[rd_addr];

   // cells hold no reset, they are nonvolatile
   always_ff @(posedge clk) begin
      if (cmd.write) begin
         mem[cmd.addr] <= base & cmd.data;
      end else if (cmd.erase) begin
         mem[cmd.addr] <= base;
      end
   end

endmodule : eas_nvm_array

/* File: eas_prog_timer.sv */
`timescale 1ns/1ps
module eas_prog_timer #(
   parameter int CNT_W = 20
) (
   input  wire logic             clk,     // core clock
   input  wire logic             rst_n,   // power-on reset, active low
   input  wire logic             load,    // start a new count
   input  wire logic [CNT_W-1:0] value,   // cycles to run
   output logic                  running, // count in progress
   output logic                  done     // last cycle of the count
);

   logic [CNT_W-1:0] cnt;

   assign running = cnt != '0;
   assign done    = cnt == CNT_W'(1);

   // down counter, stops at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= value;
      end else if (running) begin
         cnt <= cnt - CNT_W'(1);
      end
   end

endmodule : eas_prog_timer

/* File: eas_eeprom_seq_asserts.sv */
`timescale 1ns/1ps
module eas_eeprom_seq_asserts #(
   parameter int ADDR_W = 10
) (
   input wire logic              pclk,    // core clock
   input wire logic              presetn, // system reset
   input wire logic              por_n,   // power-on reset
   input wire logic              psel,    // apb select
   input wire logic              penable, // apb access
   input wire logic              pwrite,  // apb direction
   input wire logic [ADDR_W-1:0] paddr,   // apb address
   input wire logic [31:0]       pwdata,  // apb write data
   input wire logic [31:0]       prdata,  // apb read data
   input wire logic              pready,  // apb ready
   input wire logic              pslverr, // apb error
   input wire logic              irq      // interrupt
);
   localparam logic [ADDR_W-1:0] a_ctrl = ADDR_W'('h70);
   // control setup cycle of a write, and arm window with one cycle of margin
   wire        ctrl_w = psel && !penable && pwrite && paddr == a_ctrl;
   logic [2:0] arm_left;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) arm_left <= 3'h0;
      else if (psel && penable && pready && pwrite && paddr == a_ctrl && pwdata[2])
         arm_left <= 3'h5;
      else if (arm_left != 3'h0) arm_left <= arm_left - 3'h1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("pready held over one cycle");
   AST_RDY_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   AST_ERR_RDY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDATA_IDLE: assert property (!pready || pwrite |-> prdata == 32'h0)
      else $error("prdata not zero outside read answer");
   AST_RD_STALL: assert property (ctrl_w && pwdata[0] && !pwdata[1] |=>
      (pready or (!pready [*4] ##1 pready))) else $error("read stall not four cycles");
   AST_PROG_STALL: assert property (ctrl_w && pwdata[1] && !pwdata[0] |=>
      (pready or (!pready [*2] ##1 pready))) else $error("start stall not two cycles");
   AST_LATE_START: assert property (ctrl_w && pwdata[1] && !pwdata[0] && arm_left == 3'h0
      |=> pready) else $error("start outside window was stalled");
   AST_ARM_READ: assert property (pready && !pwrite && paddr == a_ctrl && prdata[2]
      |-> arm_left != 3'h0) else $error("arm bit outlived its window");
   AST_NO_WAIT: assert property (psel && !penable && paddr != a_ctrl |=> pready)
      else $error("wait state on plain register");
endmodule : eas_eeprom_seq_asserts
bind eas_eeprom_seq eas_eeprom_seq_asserts #(.ADDR_W(ADDR_W)) u_chk (
   .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq));

/* File: eas_host.sv */
`timescale 1ns/1ps
module eas_host (
   input  wire logic        pclk,    // core clock
   output logic             psel,    // apb select
   output logic             penable, // apb access phase
   output logic             pwrite,  // apb direction
   output logic [9:0]       paddr,   // apb byte address
   output logic [31:0]      pwdata,  // apb write data
   input  wire logic [31:0] prdata,  // apb read data
   input  wire logic        pready,  // apb ready
   input  wire logic        pslverr  // apb error
);
   localparam logic [9:0] a_ctrl = 10'h070;
   localparam logic [9:0] a_data = 10'h074;
   localparam logic [9:0] a_addr = 10'h078;
   int   waits; // wait states of the last access
   logic err;   // error of the last access
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // one apb access; request held until pready is sampled
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         waits++;
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      pwdata <= ~d; // released data never repeats the last value
   endtask : xfer
   // poll busy before any new operation
   task automatic wait_idle();
      logic [31:0] q;
      q = 32'h2;
      while (q[1] !== 1'b0) xfer(1'b0, a_ctrl, 32'h0, q);
   endtask : wait_idle
   // mode, address, data, arm, then start right away
   task automatic prog(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wait_idle();
      xfer(1'b1, a_ctrl, {26'h0, m, 4'h0}, q);
      xfer(1'b1, a_addr, {24'h0, a}, q);
      xfer(1'b1, a_data, {24'h0, d}, q);
      xfer(1'b1, a_ctrl, {26'h0, m, 4'h4}, q);
      xfer(1'b1, a_ctrl, {26'h0, m, 4'h2}, q);
   endtask : prog
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output int w);
      logic [31:0] q;
      wait_idle();
      xfer(1'b1, a_addr, {24'h0, a}, q);
      xfer(1'b1, a_ctrl, 32'h1, q);
      w = waits;
      xfer(1'b0, a_data, 32'h0, q);
      d = q[7:0];
   endtask : rd_byte
endmodule : eas_host

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   import eas_pkg::*;
   localparam int         atomic_cyc = 80;
   localparam int         split_cyc  = 40;
   localparam logic [9:0] a_ctrl     = 10'h070;
   localparam logic [9:0] a_addr     = 10'h078;
   localparam logic [9:0] a_ist      = 10'h080;
   localparam logic [9:0] a_imsk     = 10'h084;
   logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [9:0]  paddr;
   logic [31:0] prdata, pwdata, q;
   logic [7:0]  b;
   int          n_mismatch = 0, n_tests = 0, cyc = 0, t0, w;
   eas_eeprom_seq #(.ADDR_W(10), .ATOMIC_CYC(atomic_cyc), .SPLIT_CYC(split_cyc)) uut (
      .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   eas_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic rd(input logic [9:0] a);
      host.xfer(1'b0, a, 32'h0, q);
   endtask : rd
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask : wr
   // irq is registered, so let it land
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask : settle
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (4000) @(posedge pclk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      {presetn, por_n} = 2'b00;
      repeat (10) @(posedge pclk);
      {presetn, por_n} <= 2'b11;
      rd(a_ctrl);
      check("ctrl", q, 32'h0);
      rd(10'h3FC);
      check("unmapped", host.err, 32'h1);
      // erase-only, disturbed by a reset and by requests while busy
      host.prog(EAS_M_ERASE, 8'h05, 8'h00);
      check("start stall", host.waits, 32'h2);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      wr(a_ctrl, 32'h20);
      rd(a_ctrl);
      check("busy mode", q, 32'h12);
      wr(a_ctrl, 32'h1);
      check("refused read", host.waits, 32'h0);
      wr(a_addr, 32'h9);
      rd(a_addr);
      check("addr held", q, 32'h0);
      wr(a_imsk, 32'h1);
      host.wait_idle();
      rd(a_ist);
      check("istat", q, 32'h3);
      check("irq done", irq, 32'h1);
      wr(a_ist, 32'h3);
      settle();
      check("irq clear", irq, 32'h0);
      host.rd_byte(8'h05, b, w);
      check("erased", b, 32'hFF);
      // write-only on the erased byte, then atomic, both timed
      host.prog(EAS_M_WRITE, 8'h05, 8'hA5);
      t0 = cyc;
      host.wait_idle();
      check("split time", cyc-t0 >= split_cyc-1 && cyc-t0 <= split_cyc+4, 32'h1);
      host.rd_byte(8'h05, b, w);
      check("written", b, 32'hA5);
      host.prog(EAS_M_ATOMIC, 8'h05, 8'h3C);
      t0 = cyc;
      host.wait_idle();
      check("atomic time", cyc-t0 >= atomic_cyc-1 && cyc-t0 <= atomic_cyc+4, 32'h1);
      host.rd_byte(8'h05, b, w);
      check("atomic", b, 32'h3C);
      check("read stall", w, 32'h4);
      // reserved mode and a late start must both be refused
      host.prog(EAS_M_RSVD, 8'h06, 8'h00);
      check("rsvd stall", host.waits, 32'h0);
      rd(a_ist);
      check("rsvd refused", q, 32'h3);
      // drop only the refused flag so the late start must raise it again
      wr(a_ist, 32'h2);
      wr(a_ctrl, 32'h4);
      rd(a_ctrl);
      check("armed", q, 32'h4);
      repeat (6) @(posedge pclk);
      rd(a_ctrl);
      check("arm expired", q, 32'h0);
      wr(a_ctrl, 32'h2);
      rd(a_ctrl);
      check("late start", q, 32'h0);
      rd(a_ist);
      check("refused", q, 32'h3);
      wr(a_ist, 32'h3);
      // idle system reset returns the mode field to atomic
      wr(a_ctrl, 32'h10);
      rd(a_ctrl);
      check("mode set", q, 32'h10);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(a_ctrl);
      check("idle reset mode", q, 32'h0);
      // ready interrupt follows its enable while idle
      wr(a_ctrl, 32'h8);
      settle();
      check("ready irq", irq, 32'h1);
      wr(a_ctrl, 32'h0);
      settle();
      check("ready irq off", irq, 32'h0);
      report_and_stop();
   end
endmodule : testbench
